/* File: hdl/rsc_pkg.sv */
// Purpose: shared constants, types and helpers of the rectifier command handler
// Assumes: direct-format setpoint codes, SMBus CRC-8 packet error check
// Notes:   bit positions index the two status bytes and the crossing vector
package rsc_pkg;
    // ******************************************************************
    // command codes and addressing
    // ******************************************************************
    localparam logic [7:0]  CMD_OPERATION   = 8'h01;
    localparam logic [7:0]  CMD_CLEAR       = 8'h03;
    localparam logic [7:0]  CMD_VOUT        = 8'h21;
    localparam logic [7:0]  CMD_OVLIM       = 8'h40;
    localparam logic [7:0]  CMD_READ_STATUS = 8'hD0;
    localparam logic [7:0]  CMD_MFR_A_LO    = 8'hD2;
    localparam logic [7:0]  CMD_MFR_A_HI    = 8'hDA;
    localparam logic [7:0]  CMD_MFR_B_LO    = 8'hDC;
    localparam logic [7:0]  CMD_MFR_B_HI    = 8'hE2;
    localparam logic [7:0]  CMD_FAN_SET     = 8'hDF;
    localparam logic [3:0]  ADDR_PREFIX     = 4'h8;
    localparam logic [7:0]  ADDR_BROADCAST  = 8'h00;
    localparam logic [7:0]  CRC_POLY        = 8'h07;
    localparam logic [7:0]  READ_COUNT      = 8'h09;
    localparam logic [3:0]  READ_PEC_IDX    = 4'h9;
    localparam logic [3:0]  BIT_LAST        = 4'h7;
    localparam logic [3:0]  BIT_ACK         = 4'h8;
    localparam logic [3:0]  BIT_IDLE        = 4'hF;
    // ******************************************************************
    // scaling
    // ******************************************************************
    localparam int          VOLT_SCALE      = 400;
    localparam int          VOUT_MIN_V      = 42;
    localparam int          VOUT_MAX_V      = 58;
    localparam logic [15:0] VOUT_MIN_CODE   = 16'(VOUT_MIN_V * VOLT_SCALE);
    localparam logic [15:0] VOUT_MAX_CODE   = 16'(VOUT_MAX_V * VOLT_SCALE);
    localparam int          CUR_SCALE       = 5;
    localparam int          PD_LIMIT_A      = 10;
    localparam logic [8:0]  PD_LIMIT_CODE   = 9'(PD_LIMIT_A * CUR_SCALE);
    // ******************************************************************
    // bit positions
    // ******************************************************************
    localparam int CS_PEC = 7, CS_RESTART = 6, CS_INVALID = 5, CS_HIGHLINE = 4;
    localparam int CS_ISOFAIL = 3, CS_RESTARTED = 2, CS_BADDATA = 1, CS_ENABLE = 0;
    localparam int US_ISOPASS = 6, US_INTFAULT = 5, US_SHUTDOWN = 4, US_SERVICE = 3;
    localparam int US_EXTFAULT = 2, US_LEDTEST = 1, US_OUTON = 0;
    localparam int SY_SCL = 0, SY_SDA = 1, SY_EN = 2, SY_EXEC = 3, SY_SNAP = 4, SY_W = 5;

    typedef enum logic [2:0] {PH_ADDR, PH_CMD, PH_WDATA, PH_RDATA, PH_IGNORE} rsc_phase_type;

    function automatic logic [7:0] crc8(input logic [7:0] crc, input logic [7:0] data);
        logic [7:0] c;
        c = crc ^ data;
        for (int i = 0; i < 8; i++) begin
            c = c[7] ? ((c << 1) ^ CRC_POLY) : (c << 1);
        end
        return c;
    endfunction

    function automatic logic [3:0] data_len(input logic [7:0] cmd);
        case (cmd)
            CMD_OPERATION: data_len = 4'h1;
            CMD_VOUT,
            CMD_OVLIM:     data_len = 4'h2;
            CMD_FAN_SET:   data_len = 4'h3;
            default:       data_len = 4'h0;
        endcase
    endfunction

    function automatic logic cmd_other(input logic [7:0] cmd);
        return cmd == CMD_OPERATION || (cmd >= CMD_MFR_A_LO && cmd <= CMD_MFR_A_HI)
            || (cmd >= CMD_MFR_B_LO && cmd <= CMD_MFR_B_HI);
    endfunction
endpackage

/* File: hdl/rsc_command_handler.sv */
// Purpose: command handling and status readback of a rectifier management slave
// Assumes: scl is the link clock; sda obeys bus timing, so the link samples it directly
// Notes:   link logic idles in reset between stop and start, driven from the clk side
//
// Contract
// R1: set command adopts the programmed setpoint
// R2: after set, trim ignored until reset
// R3: accepted setpoint spans 42 V to 58 V
// R4: setpoint is volts times 400, low first
// R5: overvoltage command loads the shutdown level
// R6: long reads use write then block read
// R7: block reply starts with its byte count
// R8: multi-byte values go low byte first
// R9: master nacks the check byte then stops
// R10: status read: count, eight fields, check
// R11: alarm bits read one when present
// R12: bad check byte blocks command, sets bit7
// R13: unknown command sets bit5 and alert
// R14: bit1 holds while data out of range
// R15: bit0 mirrors the enable pin level
// R16: bits 6,4,3,2 report restart, line, isolation
// R17: isolation failure never sets internal fault
// R18: unit-state byte layout as listed
// R19: internal-alarm byte layout as listed
// R20: power delivery fault above 10 A mismatch
// R21: host sets setpoints by broadcast
// R22: host restores setpoint before hot insertion
// R23: clear command resets informational bits
// R24: every check byte covers addresses
// R25: check is SMBus CRC-8 over all bytes
`timescale 1ns/1ns
`default_nettype none
module rsc_command_handler (
    input  wire logic        clk,
    input  wire logic        sys_rst,
    input  wire logic        sclClk,
    input  wire logic        sdaIn,
    output logic             sdaOut,
    output logic             sdaOe,
    output logic             alertOut,
    output logic             alertOe,
    input  wire logic [2:0]  addrStrapIn,
    input  wire logic        enablePinIn,
    input  wire logic [15:0] trimSetpointIn,
    input  wire logic        restartPendingIn,
    input  wire logic        highLineIn,
    input  wire logic        isoFailEvt,
    input  wire logic        isoPassEvt,
    input  wire logic        restartOkEvt,
    input  wire logic        internalFaultIn,
    input  wire logic        shutdownIn,
    input  wire logic        serviceLedIn,
    input  wire logic        extFaultIn,
    input  wire logic        ledTestIn,
    input  wire logic        outputOnIn,
    input  wire logic [6:0]  alarmSrcIn,
    input  wire logic [7:0]  remainingAlarmIn,
    input  wire logic [15:0] voutReadIn,
    input  wire logic [7:0]  ioutReadIn,
    input  wire logic [7:0]  tempReadIn,
    input  wire logic [7:0]  sourcedCurrentIn,
    input  wire logic [7:0]  shareCurrentIn,
    output logic [15:0]      setpointWord,
    output logic [15:0]      ovLimitWord,
    output logic             otherCmdPulse,
    output logic [7:0]       otherCmdCode,
    output logic [23:0]      otherCmdData
);
    parameter logic [15:0] OV_LIMIT_DEFAULT = 16'hFFFF;

    // ******************************************************************
    // link side, clocked by scl
    // ******************************************************************
    rsc_pkg::rsc_phase_type phase_reg;
    logic [3:0]  bitCnt_reg, byteIdx_reg;
    logic [7:0]  rxShift_reg, txShift_reg, crc_reg, cmd_reg, txByte;
    logic [23:0] dataWord_reg;
    logic        posSample_reg, pecOk_reg, execTgl_reg, snapTgl_reg, sdaOe_reg;
    logic        busIdle_reg, linkRst, rStart, sclOld_reg;
    logic [7:0]  rxByte;
    logic [2:0]  addr1_reg, devAddr_reg;
    logic [63:0] snap_reg;

    // idle-reset between frames: no scl edge needed to end one
    assign linkRst = sys_rst | busIdle_reg;
    assign rxByte  = {rxShift_reg[6:0], sdaIn};
    // sda fell while scl was high: repeated start
    assign rStart  = posSample_reg & ~sdaIn;

    always_ff @(posedge sclClk or posedge linkRst) begin
        if (linkRst) begin
            posSample_reg <= 1'b0;
        end else begin
            posSample_reg <= sdaIn;
        end
    end

    always_ff @(negedge sclClk or posedge linkRst) begin
        if (linkRst) begin
            crc_reg <= 8'h00;
        end else if (bitCnt_reg == rsc_pkg::BIT_LAST && !rStart) begin
            crc_reg <= rsc_pkg::crc8(crc_reg, rxByte); // see R24 see R25
        end
    end

    always_comb begin
        case (byteIdx_reg)
            4'h0:    txByte = rsc_pkg::READ_COUNT; // see R7 see R10
            4'h1:    txByte = snap_reg[63:56];
            4'h2:    txByte = snap_reg[55:48];
            4'h3:    txByte = snap_reg[47:40];
            4'h4:    txByte = snap_reg[39:32];
            4'h5:    txByte = snap_reg[31:24]; // see R8
            4'h6:    txByte = snap_reg[23:16];
            4'h7:    txByte = snap_reg[15:8];
            4'h8:    txByte = snap_reg[7:0];
            4'h9:    txByte = crc_reg;
            default: txByte = 8'hFF;
        endcase
    end

    always_ff @(negedge sclClk or posedge linkRst) begin
        if (linkRst) begin
            phase_reg    <= rsc_pkg::PH_ADDR;
            bitCnt_reg   <= rsc_pkg::BIT_IDLE; // the fall closing start wraps this to zero
            byteIdx_reg  <= 4'h0;
            rxShift_reg  <= 8'h00;
            txShift_reg  <= 8'h00;
            sdaOe_reg    <= 1'b0;
        end else if (rStart) begin
            phase_reg  <= rsc_pkg::PH_ADDR;
            bitCnt_reg <= 4'h0;
            sdaOe_reg  <= 1'b0;
        end else if (bitCnt_reg == rsc_pkg::BIT_LAST) begin
            bitCnt_reg <= rsc_pkg::BIT_ACK;
            sdaOe_reg  <= 1'b0;
            case (phase_reg)
                rsc_pkg::PH_ADDR: begin
                    if (!rxByte[0] && (rxByte[7:1] == {rsc_pkg::ADDR_PREFIX, devAddr_reg}
                                       || rxByte == rsc_pkg::ADDR_BROADCAST)) begin
                        phase_reg <= rsc_pkg::PH_CMD;
                        sdaOe_reg <= 1'b1;
                    end else if (rxByte[0] && rxByte[7:1] == {rsc_pkg::ADDR_PREFIX, devAddr_reg}
                                 && cmd_reg == rsc_pkg::CMD_READ_STATUS) begin
                        phase_reg   <= rsc_pkg::PH_RDATA; // see R6
                        byteIdx_reg <= 4'h0;
                        sdaOe_reg   <= 1'b1;
                    end else begin
                        phase_reg <= rsc_pkg::PH_IGNORE;
                    end
                end
                rsc_pkg::PH_CMD: begin
                    phase_reg   <= rsc_pkg::PH_WDATA;
                    byteIdx_reg <= 4'h0;
                    sdaOe_reg   <= 1'b1;
                end
                rsc_pkg::PH_WDATA: begin
                    sdaOe_reg <= 1'b1;
                    if (byteIdx_reg == rsc_pkg::data_len(cmd_reg)) begin
                        phase_reg <= rsc_pkg::PH_IGNORE;
                    end else begin
                        byteIdx_reg <= byteIdx_reg + 4'h1;
                    end
                end
                default: begin
                end
            endcase
        end else if (bitCnt_reg == rsc_pkg::BIT_ACK) begin
            bitCnt_reg <= 4'h0;
            sdaOe_reg  <= 1'b0;
            if (phase_reg == rsc_pkg::PH_RDATA) begin
                if (sdaIn) begin
                    phase_reg <= rsc_pkg::PH_IGNORE; // see R9
                end else begin
                    txShift_reg <= {txByte[6:0], 1'b0};
                    sdaOe_reg   <= ~txByte[7];
                    byteIdx_reg <= byteIdx_reg + 4'h1;
                end
            end
        end else begin
            bitCnt_reg  <= bitCnt_reg + 4'h1;
            rxShift_reg <= rxByte;
            if (phase_reg == rsc_pkg::PH_RDATA) begin
                sdaOe_reg   <= ~txShift_reg[7];
                txShift_reg <= {txShift_reg[6:0], 1'b0};
            end
        end
    end

    // words held for the clk side until the next frame
    always_ff @(negedge sclClk or posedge sys_rst) begin
        if (sys_rst) begin
            cmd_reg      <= 8'h00;
            dataWord_reg <= 24'h000000;
            pecOk_reg    <= 1'b0;
            execTgl_reg  <= 1'b0;
            snapTgl_reg  <= 1'b0;
        end else if (!busIdle_reg && !rStart && bitCnt_reg == rsc_pkg::BIT_LAST) begin
            if (phase_reg == rsc_pkg::PH_CMD) begin
                cmd_reg <= rxByte;
                if (rxByte == rsc_pkg::CMD_READ_STATUS) begin
                    snapTgl_reg <= ~snapTgl_reg;
                end
            end else if (phase_reg == rsc_pkg::PH_WDATA) begin
                if (byteIdx_reg == rsc_pkg::data_len(cmd_reg)) begin
                    pecOk_reg   <= (rxByte == crc_reg); // see R12
                    execTgl_reg <= ~execTgl_reg;
                end else begin
                    dataWord_reg <= (byteIdx_reg == 4'h0 ? 24'h000000 : dataWord_reg)
                                    | 24'(rxByte) << {byteIdx_reg, 3'h0}; // see R4
                end
            end
        end
    end

    assign sdaOut = 1'b0;
    assign sdaOe  = sdaOe_reg;

    // ******************************************************************
    // crossing into clk
    // ******************************************************************
    logic [rsc_pkg::SY_W-1:0] s1_reg, s2_reg, s3_reg;
    logic execPulse, snapPulse, goodExec, inRange, wrVout, clearCmd;

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            s1_reg <= '0;
            s2_reg <= '0;
            s3_reg <= '0;
        end else begin
            s1_reg <= {snapTgl_reg, execTgl_reg, enablePinIn, sdaIn, sclClk};
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            addr1_reg   <= 3'h0;
            devAddr_reg <= 3'h0;
            busIdle_reg <= 1'b1;
            sclOld_reg  <= 1'b0;
        end else begin
            addr1_reg   <= addrStrapIn;
            devAddr_reg <= addr1_reg;
            sclOld_reg  <= s3_reg[rsc_pkg::SY_SCL];
            // scl high over three samples: a fast bit can never fake start or stop
            if (s2_reg[rsc_pkg::SY_SCL] && s3_reg[rsc_pkg::SY_SCL] && sclOld_reg
                && s2_reg[rsc_pkg::SY_SDA] != s3_reg[rsc_pkg::SY_SDA]) begin
                busIdle_reg <= s2_reg[rsc_pkg::SY_SDA];
            end
        end
    end

    assign execPulse = s2_reg[rsc_pkg::SY_EXEC] ^ s3_reg[rsc_pkg::SY_EXEC];
    assign snapPulse = s2_reg[rsc_pkg::SY_SNAP] ^ s3_reg[rsc_pkg::SY_SNAP];
    assign goodExec  = execPulse & pecOk_reg;
    assign inRange   = dataWord_reg[15:0] >= rsc_pkg::VOUT_MIN_CODE
                    && dataWord_reg[15:0] <= rsc_pkg::VOUT_MAX_CODE; // see R3
    assign wrVout    = goodExec && cmd_reg == rsc_pkg::CMD_VOUT;
    assign clearCmd  = goodExec && cmd_reg == rsc_pkg::CMD_CLEAR;

    // ******************************************************************
    // setpoint and limit
    // ******************************************************************
    logic        programmed_reg;
    logic [15:0] setpoint_reg;

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            programmed_reg <= 1'b0;
            setpoint_reg   <= 16'h0000;
            setpointWord   <= 16'h0000;
            ovLimitWord    <= OV_LIMIT_DEFAULT;
        end else begin
            if (wrVout && inRange) begin
                programmed_reg <= 1'b1; // see R1
                setpoint_reg   <= dataWord_reg[15:0];
            end
            setpointWord <= programmed_reg ? setpoint_reg : trimSetpointIn; // see R2
            if (goodExec && cmd_reg == rsc_pkg::CMD_OVLIM) begin
                ovLimitWord <= dataWord_reg[15:0]; // see R5
            end
        end
    end

    // ******************************************************************
    // status flags
    // ******************************************************************
    logic pecErr_reg, invalid_reg, dataBad_reg, isoFail_reg, isoPass_reg, restarted_reg, pdFault_reg;
    logic unknownCmd;
    logic [8:0] pdDiff;
    logic [7:0] cmdStatus, unitState, intAlarm;

    assign unknownCmd = goodExec && !rsc_pkg::cmd_other(cmd_reg) && cmd_reg != rsc_pkg::CMD_CLEAR
                     && cmd_reg != rsc_pkg::CMD_VOUT && cmd_reg != rsc_pkg::CMD_OVLIM
                     && cmd_reg != rsc_pkg::CMD_READ_STATUS;
    assign pdDiff = sourcedCurrentIn > shareCurrentIn ? 9'(sourcedCurrentIn - shareCurrentIn)
                                                      : 9'(shareCurrentIn - sourcedCurrentIn);

    // set wins over the clear command in every sticky flag
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            pecErr_reg    <= 1'b0;
            invalid_reg   <= 1'b0;
            isoFail_reg   <= 1'b0;
            isoPass_reg   <= 1'b0;
            restarted_reg <= 1'b0;
        end else begin
            pecErr_reg    <= (pecErr_reg & ~clearCmd) | (execPulse & ~pecOk_reg); // see R12
            invalid_reg   <= (invalid_reg & ~clearCmd) | unknownCmd; // see R13
            isoFail_reg   <= (isoFail_reg & ~clearCmd) | isoFailEvt; // see R23
            isoPass_reg   <= (isoPass_reg & ~clearCmd) | isoPassEvt;
            restarted_reg <= (restarted_reg & ~clearCmd) | restartOkEvt;
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            dataBad_reg <= 1'b0;
            pdFault_reg <= 1'b0;
        end else begin
            if (wrVout) begin
                dataBad_reg <= ~inRange; // see R14
            end
            pdFault_reg <= pdDiff > rsc_pkg::PD_LIMIT_CODE; // see R20
        end
    end

    always_comb begin
        cmdStatus = 8'h00;
        cmdStatus[rsc_pkg::CS_PEC]       = pecErr_reg; // see R11
        cmdStatus[rsc_pkg::CS_RESTART]   = restartPendingIn; // see R16
        cmdStatus[rsc_pkg::CS_INVALID]   = invalid_reg;
        cmdStatus[rsc_pkg::CS_HIGHLINE]  = highLineIn;
        cmdStatus[rsc_pkg::CS_ISOFAIL]   = isoFail_reg;
        cmdStatus[rsc_pkg::CS_RESTARTED] = restarted_reg;
        cmdStatus[rsc_pkg::CS_BADDATA]   = dataBad_reg;
        cmdStatus[rsc_pkg::CS_ENABLE]    = s2_reg[rsc_pkg::SY_EN]; // see R15
        unitState = 8'h00;
        unitState[rsc_pkg::US_ISOPASS]  = isoPass_reg; // see R18
        unitState[rsc_pkg::US_INTFAULT] = internalFaultIn; // see R17
        unitState[rsc_pkg::US_SHUTDOWN] = shutdownIn;
        unitState[rsc_pkg::US_SERVICE]  = serviceLedIn;
        unitState[rsc_pkg::US_EXTFAULT] = extFaultIn;
        unitState[rsc_pkg::US_LEDTEST]  = ledTestIn;
        unitState[rsc_pkg::US_OUTON]    = outputOnIn;
        intAlarm = {alarmSrcIn, pdFault_reg}; // see R19
    end

    // snapshot stays still while the link shifts it out
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            snap_reg <= 64'h0;
        end else if (snapPulse) begin
            snap_reg <= {cmdStatus, unitState, intAlarm, remainingAlarmIn,
                         voutReadIn[7:0], voutReadIn[15:8], ioutReadIn, tempReadIn}; // see R10
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            otherCmdPulse <= 1'b0;
            otherCmdCode  <= 8'h00;
            otherCmdData  <= 24'h000000;
        end else begin
            otherCmdPulse <= goodExec && rsc_pkg::cmd_other(cmd_reg);
            if (goodExec && rsc_pkg::cmd_other(cmd_reg)) begin
                otherCmdCode <= cmd_reg;
                otherCmdData <= dataWord_reg;
            end
        end
    end

    assign alertOut = 1'b0;
    assign alertOe  = invalid_reg; // see R13

    // ******************************************************************
    // checks
    // ******************************************************************
    sequence s_good_vout;
        wrVout && inRange;
    endsequence

    setpoint_adopt_a: assert property (@(posedge clk) disable iff (sys_rst) // see R1
        s_good_vout |=> programmed_reg && setpoint_reg == $past(dataWord_reg[15:0])
                        ##1 setpointWord == $past(dataWord_reg[15:0], 2))
        else $error("setpoint not adopted");
    trim_ignored_a: assert property (@(posedge clk) disable iff (sys_rst) // see R2
        programmed_reg && $past(programmed_reg) |-> setpointWord == $past(setpoint_reg))
        else $error("trim used after set");
    range_reject_a: assert property (@(posedge clk) disable iff (sys_rst) // see R3
        wrVout && !inRange |=> dataBad_reg && $stable(setpoint_reg))
        else $error("bad setpoint accepted");
    ovlimit_load_a: assert property (@(posedge clk) disable iff (sys_rst) // see R5
        goodExec && cmd_reg == rsc_pkg::CMD_OVLIM |=> ovLimitWord == $past(dataWord_reg[15:0]))
        else $error("limit not loaded");
    pec_block_a: assert property (@(posedge clk) disable iff (sys_rst) // see R12
        execPulse && !pecOk_reg |=> pecErr_reg && $stable(setpoint_reg) && $stable(ovLimitWord))
        else $error("bad check byte not blocked");
    invalid_alert_a: assert property (@(posedge clk) disable iff (sys_rst) // see R13
        unknownCmd |=> invalid_reg && alertOe)
        else $error("unknown not flagged");
    databad_hold_a: assert property (@(posedge clk) disable iff (sys_rst) // see R14
        clearCmd && dataBad_reg |=> dataBad_reg)
        else $error("clear dropped data range flag");
    enable_mirror_a: assert property (@(posedge clk) disable iff (sys_rst) // see R15
        enablePinIn [*3] |-> cmdStatus[rsc_pkg::CS_ENABLE])
        else $error("enable bit does not follow pin");
    clear_info_a: assert property (@(posedge clk) disable iff (sys_rst) // see R23
        clearCmd && !isoFailEvt && !isoPassEvt && !restartOkEvt |=>
        !isoFail_reg && !isoPass_reg && !restarted_reg && !invalid_reg && !pecErr_reg)
        else $error("clear left info bits");
    pd_fault_a: assert property (@(posedge clk) disable iff (sys_rst) // see R20
        pdDiff > rsc_pkg::PD_LIMIT_CODE |=> intAlarm[0])
        else $error("power delivery fault missed");
endmodule
`default_nettype wire

/* File: tb/rsc_host_model.sv */
// Purpose: bus master model for the rectifier link
// Assumes: sda has a pull-up; scl rests high between frames
// Notes:   sda moves 1 ns after scl falls, 15 ns per bit
`timescale 1ns/1ns
`default_nettype none
module rsc_host_model (
    output logic      sclClk,
    output logic      sdaPull,
    input  wire logic sdaLine
);
    initial begin
        sclClk = 1'b1;
        sdaPull = 1'b0;
    end
    // start and stop held long for the clk side
    task automatic start();
        #1 sdaPull = 1'b0;
        #6 sclClk = 1'b1;
        #27 sdaPull = 1'b1;
        #40 sclClk = 1'b0;
    endtask
    task automatic stop();
        #1 sdaPull = 1'b1;
        #6 sclClk = 1'b1;
        #27 sdaPull = 1'b0;
        #100;
    endtask
    task automatic xfer(input logic [7:0] tx, input logic ninth, output logic [7:0] rx, output logic ack);
        logic [8:0] v, s;
        v = {tx, ninth};
        for (int i = 8; i >= 0; i--) begin
            #1 sdaPull = ~v[i];
            #6 sclClk = 1'b1;
            s = {s[7:0], sdaLine};
            #8 sclClk = 1'b0;
        end
        {rx, ack} = s;
    endtask
endmodule
`default_nettype wire

/* File: tb/rsc_command_handler_tb.sv */
// Purpose: self-checking bench of the rectifier command handler
// Assumes: strap 5, so the device answers at 8Ah and 8Bh
// Notes:   expectations queue up; a monitor pops one per observed value
`timescale 1ns/1ns
`default_nettype none
module rsc_command_handler_tb;
    logic clk, sys_rst, sclClk, sdaOe, alertOe, hostPull, enablePinIn, restartPendingIn, highLineIn, ak;
    logic isoFailEvt, isoPassEvt, restartOkEvt, internalFaultIn, shutdownIn, serviceLedIn, extFaultIn;
    logic ledTestIn, outputOnIn, otherCmdPulse;
    logic [23:0] otherCmdData;
    logic [6:0] alarmSrcIn;
    logic [7:0] remainingAlarmIn, ioutReadIn, tempReadIn, sourcedCurrentIn, shareCurrentIn, rx, crc, otherCmdCode;
    logic [15:0] trimSetpointIn, voutReadIn, setpointWord, ovLimitWord, seenVal;
    logic [15:0] expQ[$];
    int failCount = 0;
    int samplesChecked = 0;
    event gotEv;
    wire logic sdaIn = ~(hostPull | sdaOe);
    rsc_command_handler i_rsc_command_handler (.*, .sdaOut(), .alertOut(), .addrStrapIn(3'h5));
    rsc_host_model i_rsc_host_model (.sclClk, .sdaPull(hostPull), .sdaLine(sdaIn));
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    function automatic logic [7:0] crcStep(input logic [7:0] c, input logic [7:0] d);
        c = c ^ d;
        for (int i = 0; i < 8; i++) c = {c[6:0], 1'b0} ^ (c[7] ? 8'h07 : 8'h00);
        return c;
    endfunction
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        samplesChecked++;
        if (seen !== exp) begin
            failCount++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic see(input logic [15:0] v);
        seenVal = v;
        ->gotEv;
        #1;
    endtask
    initial forever begin
        @gotEv;
        check(seenVal, expQ.pop_front());
    end
    task automatic xb(input logic [7:0] b, input logic ninth);
        i_rsc_host_model.xfer(b, ninth, rx, ak);
        crc = crcStep(crc, b);
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] c, input logic [15:0] d, input logic [7:0] err);
        crc = 8'h00;
        i_rsc_host_model.start();
        xb(a, 1'b1);
        expQ.push_back(16'h0000);
        see({15'h0000, ak});
        xb(c, 1'b1);
        if (c == 8'h21 || c == 8'h40) begin
            xb(d[7:0], 1'b1);
            xb(d[15:8], 1'b1);
        end
        xb(crc ^ err, 1'b1);
        i_rsc_host_model.stop();
        repeat (8) @(posedge clk);
        #1 $display("write %h done", c);
    endtask
    task automatic rd(input logic [5:0] f, input logic pd);
        logic [7:0] e[10];
        e[0] = 8'h09;
        e[1] = {f[4], restartPendingIn, f[3], highLineIn, f[2], f[1], f[0], enablePinIn};
        e[2] = {1'b0, f[5], internalFaultIn, shutdownIn, serviceLedIn, extFaultIn, ledTestIn, outputOnIn};
        e[3] = {alarmSrcIn, pd};
        e[4] = remainingAlarmIn;
        {e[6], e[5]} = voutReadIn;
        e[7] = ioutReadIn;
        e[8] = tempReadIn;
        crc = crcStep(crcStep(crcStep(8'h00, 8'h8A), 8'hD0), 8'h8B);
        for (int i = 0; i < 9; i++) crc = crcStep(crc, e[i]);
        e[9] = crc;
        for (int i = 0; i < 10; i++) expQ.push_back({8'h00, e[i]});
        i_rsc_host_model.start();
        xb(8'h8A, 1'b1);
        xb(8'hD0, 1'b1);
        i_rsc_host_model.start();
        xb(8'h8B, 1'b1);
        for (int i = 0; i < 10; i++) begin
            xb(8'hFF, i == 9);
            see({8'h00, rx});
        end
        i_rsc_host_model.stop();
        repeat (8) @(posedge clk);
        #1 $display("readback done");
    endtask
    task automatic randIn(input logic pdBit);
        {restartPendingIn, highLineIn, internalFaultIn, shutdownIn, serviceLedIn, extFaultIn, ledTestIn,
            outputOnIn, enablePinIn, alarmSrcIn} = 16'($urandom);
        {remainingAlarmIn, voutReadIn, ioutReadIn} = $urandom;
        tempReadIn = 8'($urandom);
        sourcedCurrentIn = 8'($urandom_range(0, 150));
        shareCurrentIn = sourcedCurrentIn + (pdBit ? 8'h33 : 8'h32);
    endtask
    task automatic completeRun();
        $display("checks %0d mismatches %0d", samplesChecked, failCount);
        if (failCount == 0 && samplesChecked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    initial begin
        #200000 failCount++;
        completeRun();
    end
    initial begin
        void'($urandom(1390));
        sys_rst = 1'b1;
        {isoFailEvt, isoPassEvt, restartOkEvt} = 3'h0;
        trimSetpointIn = 16'h5000;
        randIn(1'b0);
        repeat (16) @(posedge clk);
        #1 sys_rst = 1'b0;
        repeat (8) @(posedge clk);
        #1 expQ.push_back(16'h5000);
        see(setpointWord);
        wr(8'h00, 8'h21, 16'h4ED4, 8'h00);
        expQ.push_back(16'h4ED4);
        trimSetpointIn = 16'h5100;
        repeat (4) @(posedge clk);
        see(setpointWord);
        wr(8'h8A, 8'h40, 16'hE290, 8'h00);
        expQ.push_back(16'hE290);
        see(ovLimitWord);
        wr(8'h8A, 8'h21, 16'h419F, 8'h00);
        wr(8'h8A, 8'h55, 16'h0000, 8'h00);
        expQ.push_back(16'h0001);
        see({15'h0000, alertOe});
        wr(8'h8A, 8'h21, 16'h5000, 8'h01);
        expQ.push_back(16'h4ED4);
        see(setpointWord);
        {isoFailEvt, isoPassEvt, restartOkEvt} = 3'h7;
        randIn(1'b1);
        internalFaultIn = 1'b0;
        @(posedge clk);
        #1 {isoFailEvt, isoPassEvt, restartOkEvt} = 3'h0;
        rd(6'h3F, 1'b1);
        wr(8'h8A, 8'h03, 16'h0000, 8'h00);
        randIn(1'b0);
        rd(6'h01, 1'b0);
        wr(8'h8A, 8'h21, 16'h5AA0, 8'h00);
        expQ.push_back(16'h5AA0);
        see(setpointWord);
        wr(8'h8A, 8'h03, 16'h0000, 8'h00);
        rd(6'h00, 1'b0);
        wr(8'h8A, 8'hD4, 16'h0000, 8'h00);
        expQ.push_back(16'h00D4);
        see({8'h00, otherCmdCode});
        completeRun();
    end
endmodule
`default_nettype wire
